// ==== hw/mvsr_regs.svh ====
`ifndef MVSR_REGS_SVH
`define MVSR_REGS_SVH

// ==========================================================
// geometry
`define MVSR_SR_W 40
`define MVSR_NQ 5
`define MVSR_STEP_Q10 10
`define MVSR_STEP_Q8 8
`define MVSR_OVL_LANE 32
`define MVSR_Q10_LAST 39

// ==========================================================
// register byte offsets (haddr[7:0])
`define MVSR_OFS_CTRL 8'h00
`define MVSR_OFS_STATUS 8'h04
`define MVSR_OFS_LOADCNT 8'h08
`define MVSR_OFS_LATCH_LO 8'h0C
`define MVSR_OFS_LATCH_HI 8'h10

// ==========================================================
// field positions
`define MVSR_CTRL_FORCE 0
`define MVSR_STAT_MODE_LSB 0
`define MVSR_STAT_OVR 2
`define MVSR_STAT_FORCE 3
`define MVSR_STAT_Q_LSB 8
`define MVSR_CNT_W 16

// ==========================================================
// reset values
`define MVSR_CTRL_RST 1'h0
`define MVSR_CNT_RST 16'h0000
`define MVSR_Q_RST 5'h00

`endif

// ==== hw/mvsr_pkg.sv ====
`include "mvsr_regs.svh"

package mvsr_pkg;

  // ==========================================================
  // configuration modes
  typedef enum logic [1:0] {
    MVSR_MODE_Q10 = 2'b00,
    MVSR_MODE_Q8 = 2'b01,
    MVSR_MODE_OVL = 2'b10
  } mvsr_mode_t;

  // ==========================================================
  // whole clocked state of the top module
  typedef struct packed {
    logic [`MVSR_SR_W-1:0] sr;
    logic [`MVSR_NQ-1:0] q;
    logic force_sw;
    logic [`MVSR_CNT_W-1:0] load_cnt;
    logic dph_valid;
    logic dph_write;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
  } mvsr_state_t;

  // select lo wins over select hi
  function automatic mvsr_mode_t mvsr_decode(input logic hi, input logic lo);
    if (lo) begin
      return MVSR_MODE_Q8;
    end else if (hi) begin
      return MVSR_MODE_OVL;
    end else begin
      return MVSR_MODE_Q10;
    end
  endfunction

endpackage

// ==== hw/mvsr_in_latch.sv ====
`include "mvsr_regs.svh"

module mvsr_in_latch #(
  parameter int W = `MVSR_SR_W
) (
  input wire logic latch_load_n_i,
  input wire logic [W-1:0] pixel_par_in_i,
  output logic [W-1:0] latch_o
);

  // ==========================================================
  // level latch: open while strobe low, frozen from its rising edge
  // not clocked, so the frame buffer side may run at any rate
  always_latch begin
    if (!latch_load_n_i) begin
      latch_o = pixel_par_in_i;
    end
  end

endmodule

// ==== hw/mvsr_tap_mux.sv ====
`include "mvsr_regs.svh"

module mvsr_tap_mux (
  input wire logic [`MVSR_SR_W-1:0] sr_i,
  input wire mvsr_pkg::mvsr_mode_t mode_i,
  input wire logic [`MVSR_NQ-1:0] host_addr_in_i,
  input wire logic addr_override_n_i,
  output logic [`MVSR_NQ-1:0] q_nxt_o
);

  // ==========================================================
  // per-output pick of the 10-spaced or 8-spaced tap
  always_comb begin
    logic [`MVSR_NQ-1:0] data;
    logic ovl_kill;
    data = '0;
    ovl_kill = 1'b0;
    for (int k = 0; k < `MVSR_NQ - 1; k++) begin
      if (mode_i == mvsr_pkg::MVSR_MODE_Q10) begin
        data[k] = sr_i[k * `MVSR_STEP_Q10];
      end else begin
        data[k] = sr_i[k * `MVSR_STEP_Q8];
      end
    end
    // lane 4 has no meaning in quad 10-bit; last bit is its second tap
    if (mode_i == mvsr_pkg::MVSR_MODE_Q10) begin
      data[`MVSR_NQ-1] = sr_i[`MVSR_Q10_LAST];
    end else begin
      data[`MVSR_NQ-1] = sr_i[`MVSR_OVL_LANE];
    end
    // overlay bit at its tap clears pixel lanes so overlay can be ORed in
    ovl_kill = (mode_i == mvsr_pkg::MVSR_MODE_OVL) && sr_i[`MVSR_OVL_LANE];
    if (ovl_kill) begin
      data[`MVSR_NQ-2:0] = '0;
    end
    if (addr_override_n_i) begin
      q_nxt_o = data;
    end else begin
      q_nxt_o = host_addr_in_i;
    end
  end

endmodule

// ==== hw/mvsr_top.sv ====
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`include "mvsr_regs.svh"

// How it works
// - input latch is transparent while latch strobe low, holds from its rising edge
// - shift-load low at a clock edge copies the whole latch into the register
// - each output picks one of two taps or an address bit, then registered
// - shift enable low advances the register each clock; high holds for zoom
// - force input high drives all outputs zero at once, without a clock
// - serial input enters the top bit on every shift; tie low if unused
// - select lo high gives five 8-bit; hi only gives overlay; none gives 4x10
// - in 4x10, outputs 0..3 start at bits 0, 10, 20, 30, ascending
// - in 5x8, outputs 0..4 start at bits 0, 8, 16, 24, 32, ascending
// - address override low puts host address on outputs instead of shift data
// - outputs change only after a clock edge except when force acts, override path registered too
// - overlay mode: four 8-bit pixel ports plus bits 32..39 as overlay port
// - overlay mode: an overlay-active one forces outputs 0..3 to zero
module mvsr_top #(
  parameter int SR_W = `MVSR_SR_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic latch_load_n_i,
  input wire logic [SR_W-1:0] pixel_par_in_i,
  input wire logic shift_load_n_i,
  input wire logic shift_enable_n_i,
  input wire logic serial_data_in_i,
  input wire logic cfg_select_lo_i,
  input wire logic cfg_select_hi_i,
  input wire logic addr_override_n_i,
  input wire logic [`MVSR_NQ-1:0] host_addr_in_i,
  input wire logic out_force_i,
  output logic [`MVSR_NQ-1:0] tap_out_o,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o
);

  // ==========================================================
  // elaboration check
  generate
    if (SR_W != `MVSR_SR_W) begin : g_bad_width
      $error("tap positions are fixed for a 40-bit register");
    end
  endgenerate

  // ==========================================================
  // state
  mvsr_pkg::mvsr_state_t st_r;
  mvsr_pkg::mvsr_state_t st_nxt;
  logic [SR_W-1:0] latch_q;
  logic [`MVSR_NQ-1:0] q_nxt;
  mvsr_pkg::mvsr_mode_t mode;
  logic ahb_take;
  logic load_now;

  // ==========================================================
  // input latch and tap selection
  mvsr_in_latch #(
    .W(SR_W)
  ) u_latch (
    .latch_load_n_i(latch_load_n_i),
    .pixel_par_in_i(pixel_par_in_i),
    .latch_o(latch_q)
  );

  // select pins come straight from the controller on this clock
  assign mode = mvsr_pkg::mvsr_decode(cfg_select_hi_i, cfg_select_lo_i);

  mvsr_tap_mux u_mux (
    .sr_i(st_r.sr),
    .mode_i(mode),
    .host_addr_in_i(host_addr_in_i),
    .addr_override_n_i(addr_override_n_i),
    .q_nxt_o(q_nxt)
  );

  // ==========================================================
  // register read decode
  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input mvsr_pkg::mvsr_state_t s,
                                          input logic [SR_W-1:0] lat,
                                          input mvsr_pkg::mvsr_mode_t m);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `MVSR_OFS_CTRL: begin
        w[`MVSR_CTRL_FORCE] = s.force_sw;
      end
      `MVSR_OFS_STATUS: begin
        w[`MVSR_STAT_MODE_LSB +: 2] = m;
        w[`MVSR_STAT_OVR] = ~addr_override_n_i;
        w[`MVSR_STAT_FORCE] = out_force_i | s.force_sw;
        w[`MVSR_STAT_Q_LSB +: `MVSR_NQ] = s.q;
      end
      `MVSR_OFS_LOADCNT: begin
        w[`MVSR_CNT_W-1:0] = s.load_cnt;
      end
      // latch may move under a read while its strobe is low
      `MVSR_OFS_LATCH_LO: begin
        w = lat[31:0];
      end
      `MVSR_OFS_LATCH_HI: begin
        w[SR_W-33:0] = lat[SR_W-1:32];
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  assign ahb_take = hsel_i && htrans_i[1] && hready_i;
  assign load_now = !shift_load_n_i;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    // load beats shift; shift advances toward bit 0 so low bits leave first
    if (load_now) begin
      st_nxt.sr = latch_q;
    end else if (!shift_enable_n_i) begin
      st_nxt.sr = {serial_data_in_i, st_r.sr[SR_W-1:1]};
    end
    st_nxt.q = q_nxt;
    if (load_now) begin
      st_nxt.load_cnt = st_r.load_cnt + 16'h0001;
    end
    // bus data phase: writes land here
    st_nxt.dph_valid = ahb_take;
    st_nxt.dph_write = hwrite_i;
    st_nxt.dph_addr = haddr_i[7:0];
    st_nxt.rdata = 32'h0000_0000;
    if (ahb_take && !hwrite_i) begin
      st_nxt.rdata = rd_word(haddr_i[7:0], st_r, latch_q, mode);
    end
    if (st_r.dph_valid && st_r.dph_write) begin
      case (st_r.dph_addr)
        `MVSR_OFS_CTRL: begin
          st_nxt.force_sw = hwdata_i[`MVSR_CTRL_FORCE];
        end
        `MVSR_OFS_LOADCNT: begin
          // a load in the same cycle is counted, not lost
          st_nxt.load_cnt = load_now ? 16'h0001 : `MVSR_CNT_RST;
        end
        default: begin
          st_nxt.force_sw = st_r.force_sw;
        end
      endcase
    end
    st_nxt.rdy = 1'b1;
    st_nxt.resp = 1'b0;
    // shift register stays unreset on purpose
    if (rst_i) begin
      st_nxt.q = `MVSR_Q_RST;
      st_nxt.force_sw = `MVSR_CTRL_RST;
      st_nxt.load_cnt = `MVSR_CNT_RST;
      st_nxt.dph_valid = 1'b0;
      st_nxt.dph_write = 1'b0;
      st_nxt.dph_addr = 8'h00;
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.rdy = 1'b1;
      st_nxt.resp = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    st_r <= st_nxt;
  end

  // ==========================================================
  // outputs
  // force must act without a clock, so one gate follows the register
  assign tap_out_o = st_r.q & {`MVSR_NQ{~(out_force_i | st_r.force_sw)}};
  assign hreadyout_o = st_r.rdy;
  assign hresp_o = st_r.resp;
  assign hrdata_o = st_r.rdata;

endmodule

// ==== test/mvsr_sva.sv ====
`include "mvsr_regs.svh"

// ==========================================
// pin-level checks on the top module
module mvsr_sva (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic shift_load_n_i,
  input wire logic shift_enable_n_i,
  input wire logic cfg_select_lo_i,
  input wire logic cfg_select_hi_i,
  input wire logic addr_override_n_i,
  input wire logic [`MVSR_NQ-1:0] host_addr_in_i,
  input wire logic out_force_i,
  input wire logic [`MVSR_NQ-1:0] tap_out_o,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // shift register holds no defined data until a parallel load has landed
  logic seen_load_r = 1'b0;
  always @(posedge clk_sys_i) begin
    seen_load_r <= seen_load_r | !shift_load_n_i;
  end
  a_force_zero: assert property (out_force_i |-> tap_out_o == 5'h00)
    else $error("force left outputs set");
  a_override_addr: assert property (!addr_override_n_i ##1 !out_force_i |->
    tap_out_o == $past(host_addr_in_i) || tap_out_o == 5'h00) else $error("address not shown");
  // the soft force bit is only written while the pixel path shifts, so stable holds
  a_hold_zoom: assert property ((shift_enable_n_i && shift_load_n_i && addr_override_n_i
    && !out_force_i) ##1 (addr_override_n_i && !out_force_i) ##1 !out_force_i
    |-> $stable(tap_out_o)) else $error("held register changed output");
  a_overlay_kill: assert property ($past(cfg_select_hi_i && !cfg_select_lo_i
    && addr_override_n_i) && tap_out_o[4] |-> tap_out_o[3:0] == 4'h0) else $error("no kill");
  a_q8_lanes: assert property ((seen_load_r && cfg_select_lo_i && !shift_enable_n_i
    && shift_load_n_i && addr_override_n_i && !out_force_i)[*8] ##1 (cfg_select_lo_i
    && addr_override_n_i) ##1 !out_force_i |-> tap_out_o[3:0] == $past(tap_out_o[4:1], 8))
    else $error("lane slip");
  a_rdata_idle: assert property (!(hsel_i && htrans_i[1] && hready_i && !hwrite_i)
    |=> hrdata_o == 32'h00000000) else $error("read data outside data phase");
  a_resp_okay: assert property (hresp_o == 1'h0) else $error("error response");
  a_ready_high: assert property (hreadyout_o == 1'h1) else $error("wait state inserted");
endmodule

bind mvsr_top mvsr_sva i_mvsr_sva (.clk_sys_i, .rst_i, .shift_load_n_i, .shift_enable_n_i,
  .cfg_select_lo_i, .cfg_select_hi_i, .addr_override_n_i, .host_addr_in_i, .out_force_i,
  .tap_out_o, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o);

// ==== test/mvsr_fb_model.sv ====
// ==========================================
// frame buffer and timing controller
module mvsr_fb_model (
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic ovl_i,
  input wire logic [39:0] word_i,
  input wire logic [31:0] ovl_plane_i,
  output logic latch_load_n_o,
  output logic shift_load_n_o,
  output logic [39:0] pixel_par_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  logic [39:0] w;
  initial begin
    latch_load_n_o = 1'h1;
    shift_load_n_o = 1'h1;
    pixel_par_o = 40'h0;
  end
  always_comb begin
    w = word_i;
    for (int j = 0; j < 8; j++) begin
      // overlay planes differ from pixel planes, so the kill meets live pixels
      if (ovl_i) w[32+j] = ovl_plane_i[j] | ovl_plane_i[8+j]
        | ovl_plane_i[16+j] | ovl_plane_i[24+j];
    end
  end
  // data bus released after the latch closes: show the inverse, not the old word
  always @(posedge clk_sys_i) begin
    ph <= {ph[0], go_i};
    latch_load_n_o <= !go_i;
    shift_load_n_o <= !ph[0];
    if (go_i) pixel_par_o <= w;
    else if (ph[1]) pixel_par_o <= ~pixel_par_o;
  end
endmodule

// ==== test/tb.sv ====
// ==========================================
// bench top
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, go = 0, lo = 0, hi = 0, sen = 0, sdi = 0, ovr = 1, frc = 0;
  logic hsel = 0, hwr = 0, hrdy, hrsp, lln, sln;
  logic [1:0] htr = 2'h0;
  logic [4:0] ha = 5'h00, tap;
  logic [31:0] had = 32'h0, hwd = 32'h0, hrd, opl = 32'h0;
  logic [39:0] pix, word = 40'h0, last_w;
  logic [4:0] q[$];
  int mismatches = 0, cmp_count = 0, seed = 47;
  initial forever #12.5 clk = ~clk;
  mvsr_fb_model i_mvsr_fb_model (.clk_sys_i(clk), .go_i(go), .ovl_i(hi & ~lo), .word_i(word),
    .ovl_plane_i(opl), .latch_load_n_o(lln), .shift_load_n_o(sln), .pixel_par_o(pix));
  mvsr_top i_mvsr_top (.clk_sys_i(clk), .rst_i(rst), .latch_load_n_i(lln),
    .pixel_par_in_i(pix), .shift_load_n_i(sln), .shift_enable_n_i(sen), .serial_data_in_i(sdi),
    .cfg_select_lo_i(lo), .cfg_select_hi_i(hi), .addr_override_n_i(ovr), .host_addr_in_i(ha),
    .out_force_i(frc), .tap_out_o(tap), .hsel_i(hsel), .haddr_i(had), .htrans_i(htr),
    .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hreadyout_o(hrdy),
    .hresp_o(hrsp), .hrdata_o(hrd));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic results;
    $display("compared %0d, mismatched %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(negedge clk) if (q.size() > 0) chk(tap, q.pop_front());
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int k = 0;
    hsel <= 1;
    htr <= 2'h2;
    had <= a;
    hwr <= w;
    do begin @(posedge clk); k++; end while (hrdy !== 1'h1 && k < 50);
    hsel <= 0;
    htr <= 2'h0;
    hwd <= d;
    do begin @(posedge clk); k++; end while (hrdy !== 1'h1 && k < 100);
    r = hrd;
    if (k >= 50) begin mismatches++; results(); end
  endtask
  function automatic logic [4:0] taps(logic [39:0] m, logic l, logic h);
    if (l) return {m[32], m[24], m[16], m[8], m[0]};
    if (!h) return {m[39], m[30], m[20], m[10], m[0]};
    return {m[32], m[32] ? 4'h0 : {m[24], m[16], m[8], m[0]}};
  endfunction
  // one load, then n clocks of shift; r randomises hold, override and address
  task automatic run(input logic l, h, f, r, input int n);
    logic [39:0] m;
    logic [4:0] a, e;
    logic s, z, o;
    lo <= l;
    hi <= h;
    frc <= f;
    sen <= 0;
    ovr <= 1;
    go <= 1;
    word[31:0] <= $random(seed);
    word[39:32] <= 8'($random(seed));
    opl <= $random(seed) & $random(seed) & $random(seed);
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    m = pix;
    last_w = m;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      s = 1'($random(seed));
      z = r && i < n - 1 && 1'($random(seed));
      o = !(r && $random(seed) % 4 == 0);
      a = 5'($random(seed));
      sdi <= s;
      sen <= z;
      ovr <= o;
      ha <= a;
      e = f ? 5'h00 : !o ? a : taps(m, l, h);
      if (!z) m = {s, m[39:1]};
      @(posedge clk);
      // taps of this bit stand from this edge on
      q.push_back(e);
    end
    // let the last note be compared before the next run moves force
    @(posedge clk);
    $display("pixel run done");
  endtask
  initial begin
    logic [31:0] r;
    repeat (4) @(posedge clk);
    rst <= 0;
    ahb(0, 32'h0, 32'h0, r);
    chk(r, 32'h0);
    ahb(1, 32'h0, 32'h1, r);
    ahb(0, 32'h4, 32'h0, r);
    chk(r[3], 1'h1);
    chk(tap, 5'h00);
    ahb(1, 32'h0, 32'h0, r);
    for (int c = 0; c < 4; c++) begin
      lo <= c[0];
      hi <= c[1];
      @(posedge clk);
      ahb(0, 32'h4, 32'h0, r);
      chk(r[1:0], c[0] ? 2'h1 : 2'(c));
    end
    ahb(1, 32'h40, 32'hFFFFFFFF, r);
    ahb(0, 32'h40, 32'h0, r);
    chk(r, 32'h0);
    ahb(1, 32'h8, 32'h0, r);
    $display("register test done");
    run(1, 0, 0, 0, 10);
    run(0, 0, 0, 0, 10);
    run(0, 1, 0, 1, 8);
    run(1, 1, 0, 1, 9);
    run(0, 0, 1, 1, 10);
    run(0, 0, 0, 0, 40);
    run(1, 0, 0, 1, 32);
    ahb(0, 32'h8, 32'h0, r);
    chk(r, 32'h7);
    ahb(0, 32'hC, 32'h0, r);
    chk(r, last_w[31:0]);
    ahb(0, 32'h10, 32'h0, r);
    chk(r, {24'h0, last_w[39:32]});
    results();
  end
endmodule
